// ### include/rx_filter_cfg.svh
// Purpose: Offsets, field positions, reset values and counts for the frame filter.
// Assumes: Register indices map to byte addresses at four times the index.
// Notes:   Definitions only.
`ifndef RX_FILTER_CFG_SVH
`define RX_FILTER_CFG_SVH

`define RFF_IDX_SYNC_MIN   6'h1A
`define RFF_IDX_MAX_SLOT   6'h1B
`define RFF_IDX_CARD_CFG   6'h1C
`define RFF_RST_SYNC_MIN   8'h00
`define RFF_RST_MAX_SLOT   8'h00
`define RFF_RST_CARD_CFG   8'h62
`define RFF_BIT_HALTED     2
`define RFF_SYNC_WORD      16'hB24D
`define RFF_SYNC_BASE      3'h2
`define RFF_MAX_DEFAULT    9'h100
`define RFF_REQ_WAKE       8'h52
`define RFF_GAP_BASE       4'h7
`define RFF_GAP_IDLE       4'hF
`define RFF_RESP_OKAY      2'h0
`define RFF_RESP_SLVERR    2'h2

`endif

// ### include/rx_filter_pkg.sv
// Purpose: Types shared by the frame filter and its bus.
// Assumes: Field layouts as in rx_filter_cfg.svh.
// Notes:   Types only.
package rx_filter_pkg;

	typedef struct packed {
		logic [1:0] sync_preamble_length;
		logic [5:0] min_packet_quads;
	} sync_min_t;

	typedef struct packed {
		logic       hold_until_selected;
		logic       half_slot_select;
		logic [5:0] max_packet_quads;
	} max_slot_t;

	typedef struct packed {
		logic [2:0] miller_sensitivity;
		logic [1:0] miller_time_constant;
		logic       card_halted_flag;
		logic [1:0] response_delay_extra;
	} card_cfg_t;

	typedef struct packed {
		logic       valid;
		logic [8:0] lenBytes;
	} rx_pkt_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] code;
	} req_t;

	typedef enum logic [1:0] {
		AC_IDLE,
		AC_RUN,
		AC_SELECTED
	} autocoll_t;

endpackage

// ### hw/response_gate.sv
// Purpose: Holds a transmit request until the minimum response gap has passed.
// Assumes: bitTick pulses once per data bit; all inputs share sys_clk.
// Notes:   Gap is counted from the end of the last reception.
`timescale 1ns/1ps
`include "rx_filter_cfg.svh"

module response_gate (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       rxEnd,
	input  wire logic       bitTick,
	input  wire logic       txRequest,
	input  wire logic       txBitAligned,
	input  wire logic [1:0] extraBits,
	output logic            txStart,
	output logic            txHeld
);

	logic [3:0] gapCount_q;
	logic [3:0] gapCount_d;
	logic       pending_q;
	logic       txStart_q;
	wire  [3:0] gapNeed = `RFF_GAP_BASE + {2'b00, extraBits};
	wire        gapMet  = gapCount_q >= gapNeed;
	wire        wantTx  = txRequest | pending_q;
	wire        fire    = wantTx & gapMet & txBitAligned;

	// Bit counter restarts at each end of reception and saturates.
	assign gapCount_d = rxEnd ? 4'h0 :
		((bitTick && gapCount_q != `RFF_GAP_IDLE) ? gapCount_q + 4'h1 : gapCount_q);

	// Request waits while the gap is short, then starts on alignment.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			gapCount_q <= `RFF_GAP_IDLE;
			pending_q  <= 1'b0;
			txStart_q  <= 1'b0;
		end else begin
			gapCount_q <= gapCount_d;
			pending_q  <= wantTx & ~fire;
			txStart_q  <= fire;
		end
	end

	assign txStart = txStart_q;
	assign txHeld  = pending_q;

	property p_hold_short;
		@(posedge sys_clk) disable iff (rst)
		(wantTx && !gapMet) |=> !txStart_q;
	endproperty
	a_hold_short: assert property (p_hold_short) else $error("Start inside response gap.");

	property p_start_now;
		@(posedge sys_clk) disable iff (rst)
		(wantTx && gapMet && txBitAligned) |=> txStart_q ##1 !txHeld;
	endproperty
	a_start_now: assert property (p_start_now) else $error("Late start after gap.");

	property p_gap_len;
		@(posedge sys_clk) disable iff (rst)
		txStart_q |-> ($past(gapCount_q) >= 4'h7 + {2'b00, $past(extraBits)});
	endproperty
	a_gap_len: assert property (p_gap_len) else $error("Gap shorter than needed.");

	c_delayed: cover property (@(posedge sys_clk) pending_q ##[1:20] txStart_q);

endmodule

// ### hw/contactless_rx_frame_filter.sv
// Purpose: Receive packet length filter and card mode response settings.
// Assumes: All block inputs come from logic on sys_clk; AXI4-Lite 32-bit slave.
// Notes:   Registers sit at byte address four times their index.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "rx_filter_cfg.svh"

// How it works
// - Two-bit code sets sync preamble zero bytes.
// - Accept only when four times minimum not above length.
// - Shorter packets are dropped without processing.
// - At 106 kbit without sync detect, skip checks.
// - Accept only when four times maximum covers length.
// - Maximum field zero means 256 bytes.
// - Longer packets are dropped.
// - Hold mode ends anticollision only after selection.
// - Hold mode forbids active communication.
// - Half slot bit halves 424 kbit passive slot.
// - Three-bit field sets Miller sensitivity.
// - Two-bit field sets Miller time constant.
// - Halted flag set by software or hardware.
// - While halted only request code 52h passes.
// - RF reset clears the halted flag.
// - Response gap is seven plus extra bits.
// - Early transmit waits for the gap.
// - Late transmit starts at once when aligned.
module contactless_rx_frame_filter (
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	input  wire logic [7:0]            awaddr,
	input  wire logic                  awvalid,
	output logic                       awready,
	input  wire logic [31:0]           wdata,
	input  wire logic [3:0]            wstrb,
	input  wire logic                  wvalid,
	output logic                       wready,
	output logic [1:0]                 bresp,
	output logic                       bvalid,
	input  wire logic                  bready,
	input  wire logic [7:0]            araddr,
	input  wire logic                  arvalid,
	output logic                       arready,
	output logic [31:0]                rdata,
	output logic [1:0]                 rresp,
	output logic                       rvalid,
	input  wire logic                  rready,
	input  wire logic                  rate106,
	input  wire logic                  passive424,
	input  wire logic                  syncDetectEnable,
	input  wire rx_filter_pkg::rx_pkt_t rxPkt,
	input  wire rx_filter_pkg::req_t   req,
	input  wire logic                  haltSet,
	input  wire logic                  rfReset,
	input  wire logic                  autocollStart,
	input  wire logic                  selectDone,
	input  wire logic                  cmdValid,
	input  wire logic                  rxEnd,
	input  wire logic                  bitTick,
	input  wire logic                  txRequest,
	input  wire logic                  txBitAligned,
	output logic [2:0]                 syncBytes,
	output logic [15:0]                syncWord,
	output logic                       pktAccept,
	output logic                       pktDiscard,
	output logic                       reqAccept,
	output logic                       reqIgnore,
	output logic                       autocollDone,
	output logic                       activeAllowed,
	output logic                       slotHalf,
	output logic [2:0]                 millerSens,
	output logic [1:0]                 millerTau,
	output logic                       halted,
	output logic                       txStart,
	output logic                       txHeld
);

	rx_filter_pkg::sync_min_t  cfg1_q;
	rx_filter_pkg::max_slot_t  cfg2_q;
	rx_filter_pkg::card_cfg_t  cfg3_q;
	rx_filter_pkg::autocoll_t  acState_q;
	rx_filter_pkg::autocoll_t  acState_d;
	logic        halted_q;
	logic        halted_d;
	logic        awHeld_q;
	logic        wHeld_q;
	logic        awHeld_d;
	logic        wHeld_d;
	logic [5:0]  awIdx_q;
	logic [7:0]  wByte_q;
	logic        wLane_q;
	logic        awReady_q;
	logic        wReady_q;
	logic        bValid_q;
	logic [1:0]  bResp_q;
	logic        arReady_q;
	logic        rValid_q;
	logic [31:0] rData_q;
	logic [1:0]  rResp_q;
	logic [2:0]  syncBytes_q;
	logic        pktAccept_q;
	logic        pktDiscard_q;
	logic        reqAccept_q;
	logic        reqIgnore_q;
	logic        acDone_q;
	logic        active_q;
	logic        slotHalf_q;

	// Write channel capture; address and data may arrive in either order.
	wire awTake  = awvalid & awReady_q;
	wire wTake   = wvalid & wReady_q;
	wire doWrite = awHeld_q & wHeld_q & ~bValid_q;
	assign awHeld_d = awTake | (awHeld_q & ~doWrite);
	assign wHeld_d  = wTake | (wHeld_q & ~doWrite);

	// Write decode by register index.
	wire wrSync   = doWrite & wLane_q & (awIdx_q == `RFF_IDX_SYNC_MIN);
	wire wrMax    = doWrite & wLane_q & (awIdx_q == `RFF_IDX_MAX_SLOT);
	wire wrCard   = doWrite & wLane_q & (awIdx_q == `RFF_IDX_CARD_CFG);
	wire awMapped = (awIdx_q == `RFF_IDX_SYNC_MIN) | (awIdx_q == `RFF_IDX_MAX_SLOT) |
		(awIdx_q == `RFF_IDX_CARD_CFG);

	// Read decode; the halted bit shows live hardware state.
	wire [5:0] arIdx   = araddr[7:2];
	wire       arTake  = arvalid & arReady_q;
	wire [7:0] cardRd  = {cfg3_q.miller_sensitivity, cfg3_q.miller_time_constant,
		halted_q, cfg3_q.response_delay_extra};
	wire       arMapped = (arIdx == `RFF_IDX_SYNC_MIN) | (arIdx == `RFF_IDX_MAX_SLOT) |
		(arIdx == `RFF_IDX_CARD_CFG);
	wire [7:0] rdByte  = (arIdx == `RFF_IDX_SYNC_MIN) ? cfg1_q :
		(arIdx == `RFF_IDX_MAX_SLOT) ? cfg2_q :
		(arIdx == `RFF_IDX_CARD_CFG) ? cardRd : 8'h00;

	// Bus handshake state.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			awHeld_q  <= 1'b0;
			wHeld_q   <= 1'b0;
			awReady_q <= 1'b1;
			wReady_q  <= 1'b1;
			awIdx_q   <= 6'h00;
			wByte_q   <= 8'h00;
			wLane_q   <= 1'b0;
			bValid_q  <= 1'b0;
			bResp_q   <= `RFF_RESP_OKAY;
		end else begin
			awHeld_q  <= awHeld_d;
			wHeld_q   <= wHeld_d;
			awReady_q <= ~awHeld_d;
			wReady_q  <= ~wHeld_d;
			if (awTake) begin
				awIdx_q <= awaddr[7:2];
			end
			if (wTake) begin
				wByte_q <= wdata[7:0];
				wLane_q <= wstrb[0];
			end
			if (doWrite) begin
				bValid_q <= 1'b1;
				bResp_q  <= awMapped ? `RFF_RESP_OKAY : `RFF_RESP_SLVERR;
			end else if (bready) begin
				bValid_q <= 1'b0;
			end
		end
	end

	// Read channel: one read at a time, data from a register.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			arReady_q <= 1'b1;
			rValid_q  <= 1'b0;
			rData_q   <= 32'h0000_0000;
			rResp_q   <= `RFF_RESP_OKAY;
		end else if (arTake) begin
			arReady_q <= 1'b0;
			rValid_q  <= 1'b1;
			rData_q   <= {24'h00_0000, rdByte};
			rResp_q   <= arMapped ? `RFF_RESP_OKAY : `RFF_RESP_SLVERR;
		end else if (rValid_q && rready) begin
			arReady_q <= 1'b1;
			rValid_q  <= 1'b0;
		end
	end

	// Configuration registers written by software.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cfg1_q <= `RFF_RST_SYNC_MIN;
			cfg2_q <= `RFF_RST_MAX_SLOT;
			cfg3_q <= `RFF_RST_CARD_CFG;
		end else begin
			if (wrSync) begin
				cfg1_q <= wByte_q;
			end
			if (wrMax) begin
				cfg2_q <= wByte_q;
			end
			if (wrCard) begin
				cfg3_q <= wByte_q;
			end
		end
	end

	// Halted flag: a hardware set wins over RF reset and software.
	assign halted_d = haltSet ? 1'b1 :
		rfReset ? 1'b0 :
		wrCard ? wByte_q[`RFF_BIT_HALTED] : halted_q;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			halted_q <= 1'(`RFF_RST_CARD_CFG >> `RFF_BIT_HALTED);
		end else begin
			halted_q <= halted_d;
		end
	end

	// Length bounds in bytes; a zero maximum means 256 bytes.
	wire [8:0] minBound = {1'b0, cfg1_q.min_packet_quads, 2'b00};
	wire [8:0] maxBound = (cfg2_q.max_packet_quads == 6'h00) ? `RFF_MAX_DEFAULT :
		{1'b0, cfg2_q.max_packet_quads, 2'b00};
	wire       checkOn  = ~(rate106 & ~syncDetectEnable);
	wire       minOk    = minBound <= rxPkt.lenBytes;
	wire       maxOk    = rxPkt.lenBytes <= maxBound;
	wire       lenOk    = ~checkOn | (minOk & maxOk);

	// Packet verdict; a short or long packet only raises the discard pulse.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pktAccept_q  <= 1'b0;
			pktDiscard_q <= 1'b0;
			syncBytes_q  <= `RFF_SYNC_BASE;
		end else begin
			pktAccept_q  <= rxPkt.valid & lenOk;
			pktDiscard_q <= rxPkt.valid & ~lenOk;
			syncBytes_q  <= `RFF_SYNC_BASE + {1'b0, cfg1_q.sync_preamble_length};
		end
	end

	// Request filter while halted.
	wire reqPass = ~halted_q | (req.code == `RFF_REQ_WAKE);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			reqAccept_q <= 1'b0;
			reqIgnore_q <= 1'b0;
		end else begin
			reqAccept_q <= req.valid & reqPass;
			reqIgnore_q <= req.valid & ~reqPass;
		end
	end

	// Anticollision end: in hold mode a command counts only after selection.
	always_comb begin
		acState_d = acState_q;
		unique case (acState_q)
			rx_filter_pkg::AC_IDLE: begin
				if (autocollStart) begin
					acState_d = rx_filter_pkg::AC_RUN;
				end
			end
			rx_filter_pkg::AC_RUN: begin
				if (selectDone && cfg2_q.hold_until_selected) begin
					acState_d = rx_filter_pkg::AC_SELECTED;
				end else if (cmdValid && !cfg2_q.hold_until_selected) begin
					acState_d = rx_filter_pkg::AC_IDLE;
				end
			end
			rx_filter_pkg::AC_SELECTED: begin
				if (cmdValid) begin
					acState_d = rx_filter_pkg::AC_IDLE;
				end
			end
			default: begin
				acState_d = rx_filter_pkg::AC_IDLE;
			end
		endcase
	end

	wire acEnding = (acState_q != rx_filter_pkg::AC_IDLE) &&
		(acState_d == rx_filter_pkg::AC_IDLE);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			acState_q  <= rx_filter_pkg::AC_IDLE;
			acDone_q   <= 1'b0;
			active_q   <= 1'b0;
			slotHalf_q <= 1'b0;
		end else begin
			acState_q  <= acState_d;
			acDone_q   <= acEnding;
			active_q   <= ~cfg2_q.hold_until_selected;
			slotHalf_q <= cfg2_q.half_slot_select & passive424;
		end
	end

	// Minimum response gap ahead of transmission.
	response_gate gate (
		.sys_clk      (sys_clk),
		.rst          (rst),
		.rxEnd        (rxEnd),
		.bitTick      (bitTick),
		.txRequest    (txRequest),
		.txBitAligned (txBitAligned),
		.extraBits    (cfg3_q.response_delay_extra),
		.txStart      (txStart),
		.txHeld       (txHeld)
	);

	// Outputs, all from flip-flops except syncWord, which is a constant.
	assign awready       = awReady_q;
	assign wready        = wReady_q;
	assign bvalid        = bValid_q;
	assign bresp         = bResp_q;
	assign arready       = arReady_q;
	assign rvalid        = rValid_q;
	assign rdata         = rData_q;
	assign rresp         = rResp_q;
	assign syncBytes     = syncBytes_q;
	assign syncWord      = `RFF_SYNC_WORD;
	assign pktAccept     = pktAccept_q;
	assign pktDiscard    = pktDiscard_q;
	assign reqAccept     = reqAccept_q;
	assign reqIgnore     = reqIgnore_q;
	assign autocollDone  = acDone_q;
	assign activeAllowed = active_q;
	assign slotHalf      = slotHalf_q;
	assign millerSens    = cfg3_q.miller_sensitivity;
	assign millerTau     = cfg3_q.miller_time_constant;
	assign halted        = halted_q;

	// Checks on the filter behaviour.
	property p_sync_len;
		@(posedge sys_clk) disable iff (rst)
		##1 syncBytes_q == 3'h2 + {1'b0, $past(cfg1_q.sync_preamble_length)};
	endproperty
	a_sync_len: assert property (p_sync_len) else $error("Preamble length wrong.");

	property p_too_short;
		@(posedge sys_clk) disable iff (rst)
		(rxPkt.valid && checkOn && rxPkt.lenBytes < {1'b0, cfg1_q.min_packet_quads, 2'b00})
		|=> pktDiscard_q && !pktAccept_q;
	endproperty
	a_too_short: assert property (p_too_short) else $error("Short packet kept.");

	property p_too_long;
		@(posedge sys_clk) disable iff (rst)
		(rxPkt.valid && checkOn && rxPkt.lenBytes > maxBound) |=> pktDiscard_q;
	endproperty
	a_too_long: assert property (p_too_long) else $error("Long packet kept.");

	property p_max_zero;
		@(posedge sys_clk) disable iff (rst)
		(rxPkt.valid && cfg2_q.max_packet_quads == 6'h00 && rxPkt.lenBytes == 9'h100)
		|=> pktAccept_q;
	endproperty
	a_max_zero: assert property (p_max_zero) else $error("256 byte packet lost.");

	property p_bypass;
		@(posedge sys_clk) disable iff (rst)
		(rxPkt.valid && rate106 && !syncDetectEnable) |=> pktAccept_q;
	endproperty
	a_bypass: assert property (p_bypass) else $error("Length checked at 106.");

	property p_halt_req;
		@(posedge sys_clk) disable iff (rst)
		(req.valid && halted_q && req.code != 8'h52) |=> reqIgnore_q && !reqAccept_q;
	endproperty
	a_halt_req: assert property (p_halt_req) else $error("Request passed while halted.");

	property p_rf_clear;
		@(posedge sys_clk) disable iff (rst)
		(rfReset && !haltSet) |=> !halted_q;
	endproperty
	a_rf_clear: assert property (p_rf_clear) else $error("Halt kept over RF reset.");

	property p_halt_set;
		@(posedge sys_clk) disable iff (rst)
		haltSet |=> halted_q;
	endproperty
	a_halt_set: assert property (p_halt_set) else $error("Halt set lost.");

	property p_hold_end;
		@(posedge sys_clk) disable iff (rst)
		(acState_q == rx_filter_pkg::AC_RUN && cfg2_q.hold_until_selected) |=> !acDone_q;
	endproperty
	a_hold_end: assert property (p_hold_end) else $error("Ended before selection.");

	property p_no_active;
		@(posedge sys_clk) disable iff (rst)
		cfg2_q.hold_until_selected ##1 cfg2_q.hold_until_selected |-> !active_q;
	endproperty
	a_no_active: assert property (p_no_active) else $error("Active mode in hold.");

	c_discard: cover property (@(posedge sys_clk) pktDiscard_q);
	c_selected: cover property (@(posedge sys_clk)
		acState_q == rx_filter_pkg::AC_SELECTED ##[1:50] acDone_q);
	c_wake: cover property (@(posedge sys_clk) halted_q && reqAccept_q);

endmodule

// ### tb/rf_peer_model.sv
// Purpose: Remote reader on the RF side: packets, requests, commands, bit clock.
// Assumes: Every output changes right after a rising sys_clk edge.
// Notes:   A released data field carries the inverse of its last value.
`timescale 1ns/1ps

module rf_peer_model (
	input  wire logic       sys_clk,
	output rx_filter_pkg::rx_pkt_t rxPkt,
	output rx_filter_pkg::req_t    req,
	output logic            rxEnd,
	output logic            bitTick,
	output logic            selectDone,
	output logic            cmdValid
);
	logic [1:0] tickDiv_q = 2'h0;

	// Idle levels at time zero.
	initial begin
		rxPkt = '{valid: 1'h0, lenBytes: 9'h1FF};
		req = '{valid: 1'h0, code: 8'hFF};
		{rxEnd, selectDone, cmdValid} = 3'h0;
	end

	// One data bit every four cycles while the field is on.
	always @(posedge sys_clk) tickDiv_q <= tickDiv_q + 2'h1;
	assign bitTick = (tickDiv_q == 2'h3);

	// One packet, then the length field is scrambled.
	task automatic send_pkt(input logic [8:0] len);
		@(posedge sys_clk);
		rxPkt <= '{valid: 1'h1, lenBytes: len};
		@(posedge sys_clk);
		rxPkt <= '{valid: 1'h0, lenBytes: ~len};
	endtask

	// One request code, then the code field is scrambled.
	task automatic send_req(input logic [7:0] code);
		@(posedge sys_clk);
		req <= '{valid: 1'h1, code: code};
		@(posedge sys_clk);
		req <= '{valid: 1'h0, code: ~code};
	endtask

	// Event pulse clear of a bit tick: 0 end of frame, 1 selected, 2 command.
	task automatic pulse(input int which);
		do @(posedge sys_clk); while (tickDiv_q != 2'h1);
		rxEnd <= (which == 0);
		selectDone <= (which == 1);
		cmdValid <= (which == 2);
		@(posedge sys_clk);
		{rxEnd, selectDone, cmdValid} <= 3'h0;
	endtask
endmodule

// ### tb/tb_top.sv
// Purpose: Self-checking bench for the receive frame filter.
// Assumes: Registers sit at byte address four times their index.
// Notes:   Drivers note expected results; one watcher compares them.
`timescale 1ns/1ps
`include "rx_filter_cfg.svh"

module tb_top;
	logic        sys_clk = 1'h0, rst = 1'h1;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, lfsr = 32'h34C1;
	logic [3:0]  wstrb = 4'h0;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic        rate106 = 1'h0, passive424 = 1'h0, syncDetectEnable = 1'h0, haltSet = 1'h0;
	logic        rfReset = 1'h0, autocollStart = 1'h0, txRequest = 1'h0, txBitAligned = 1'h1;
	logic        awready, wready, bvalid, arready, rvalid, pktAccept, pktDiscard, reqAccept;
	logic        reqIgnore, autocollDone, activeAllowed, slotHalf, halted, txStart, txHeld;
	logic        rxEnd, bitTick, selectDone, cmdValid;
	logic [1:0]  bresp, rresp, millerTau;
	logic [2:0]  syncBytes, millerSens;
	logic [15:0] syncWord;
	logic [1:0]  vdQ[$], rqQ[$], wrQ[$];
	logic [33:0] rdQ[$];
	logic [4:0]  txQ[$], txExp, mil;
	logic [5:0]  minQ = 6'h00, maxQ = 6'h00;
	logic [8:0]  lens[4] = '{9'h00B, 9'h00C, 9'h014, 9'h015};
	int          errors = 0, samples_checked = 0, ticks = 0, reqAge = 0, doneCount = 0;
	rx_filter_pkg::rx_pkt_t rxPkt;
	rx_filter_pkg::req_t    req;

	always #2.5 sys_clk = ~sys_clk;

	contactless_rx_frame_filter u_dut (.sys_clk, .rst, .awaddr, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .rate106, .passive424, .syncDetectEnable, .rxPkt, .req,
		.haltSet, .rfReset, .autocollStart, .selectDone, .cmdValid, .rxEnd, .bitTick, .txRequest,
		.txBitAligned, .syncBytes, .syncWord, .pktAccept, .pktDiscard, .reqAccept, .reqIgnore,
		.autocollDone, .activeAllowed, .slotHalf, .millerSens, .millerTau, .halted, .txStart,
		.txHeld);
	rf_peer_model u_peer (.sys_clk, .rxPkt, .req, .rxEnd, .bitTick, .selectDone, .cmdValid);

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Verdict, counts and the end of the run.
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic timed_out();
		errors++;
		end_of_test();
	endtask

	task automatic tally(input logic [33:0] got, input logic [33:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_rd(input logic [33:0] got, input logic [33:0] exp);
		tally(got, exp);
	endtask
	task automatic check_vd(input logic [1:0] got, input logic [1:0] exp);
		tally(34'(got), 34'(exp));
	endtask
	task automatic check_tx(input logic [4:0] got, input logic [4:0] exp);
		tally(34'(got), 34'(exp));
	endtask
	task automatic check_lvl(input logic [15:0] got, input logic [15:0] exp);
		tally(34'(got), 34'(exp));
	endtask

	// Register write; address and data offered together, each released when taken.
	task automatic axi_write(input logic [7:0] addr, input logic [7:0] data, input logic [1:0] resp);
		int n;
		n = 0;
		wrQ.push_back(resp);
		awaddr <= addr;
		wdata <= {lfsr[23:0], data};
		lfsr = lfsr_next(lfsr);
		wstrb <= {lfsr[27:25], addr[1:0] == 2'h0};
		{awvalid, wvalid} <= 2'h3;
		do begin
			@(posedge sys_clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			n++;
		end while (((awvalid && !awready) || (wvalid && !wready)) && n < 50);
		bready <= 1'h1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (!bvalid && n < 100);
		bready <= 1'h0;
		if (n >= 100) timed_out();
		@(posedge sys_clk);
	endtask

	// Register read; the watcher compares data and response.
	task automatic axi_read(input logic [7:0] addr, input logic [33:0] exp);
		int n;
		n = 0;
		rdQ.push_back(exp);
		araddr <= addr;
		arvalid <= 1'h1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (!arready && n < 50);
		arvalid <= 1'h0;
		rready <= 1'h1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (!rvalid && n < 100);
		rready <= 1'h0;
		if (n >= 100) timed_out();
		@(posedge sys_clk);
	endtask

	// Local pulse: 0 halt entry, 1 RF reset, 2 anticollision start, 3 transmit request.
	task automatic pulse_in(input int which);
		case (which)
			0: haltSet <= 1'h1;
			1: rfReset <= 1'h1;
			2: autocollStart <= 1'h1;
			default: txRequest <= 1'h1;
		endcase
		@(posedge sys_clk);
		{haltSet, rfReset, autocollStart, txRequest} <= 4'h0;
		@(posedge sys_clk);
	endtask

	task automatic set_len(input logic [5:0] mn, input logic [5:0] mx);
		minQ = mn;
		maxQ = mx;
		axi_write(8'h68, {2'h0, mn}, `RFF_RESP_OKAY);
		axi_write(8'h6C, {2'h0, mx}, `RFF_RESP_OKAY);
	endtask

	// Packet with its verdict from the length bounds.
	task automatic pkt(input logic [8:0] len);
		logic [9:0] hi;
		hi = (maxQ == 6'h00) ? 10'(`RFF_MAX_DEFAULT) : {2'h0, maxQ, 2'h0};
		if ((rate106 && !syncDetectEnable) ||
				({1'h0, len} >= {2'h0, minQ, 2'h0} && {1'h0, len} <= hi))
			vdQ.push_back(2'h2);
		else
			vdQ.push_back(2'h1);
		u_peer.send_pkt(len);
	endtask

	task automatic reqc(input logic [7:0] code, input logic haltExp);
		rqQ.push_back((!haltExp || code == `RFF_REQ_WAKE) ? 2'h2 : 2'h1);
		u_peer.send_req(code);
	endtask

	task automatic settle();
		int n;
		n = 0;
		while ((vdQ.size() + rqQ.size() + txQ.size()) != 0 && n < 300) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 300) timed_out();
		repeat (3) @(posedge sys_clk);
	endtask

	// Compares each result with the oldest note of its kind.
	always @(posedge sys_clk) begin
		if (!rst) begin
			if (pktAccept | pktDiscard)
				check_vd({pktAccept, pktDiscard}, vdQ.size() ? vdQ.pop_front() : 2'hx);
			if (reqAccept | reqIgnore)
				check_vd({reqAccept, reqIgnore}, rqQ.size() ? rqQ.pop_front() : 2'hx);
			if (rvalid && rready)
				check_rd({rresp, rdata}, rdQ.size() ? rdQ.pop_front() : 34'hx);
			if (bvalid && bready)
				check_lvl({14'h0, bresp}, {14'h0, wrQ.size() ? wrQ.pop_front() : 2'hx});
			if (txStart) begin
				txExp = txQ.size() ? txQ.pop_front() : 5'hx;
				if (txExp !== 5'h1F)
					check_tx(txExp[4] ? {1'h1, reqAge[3:0]} : {1'h0, ticks[3:0]}, txExp);
			end
			doneCount = doneCount + int'(autocollDone);
		end
		ticks = rxEnd ? 0 : ticks + int'(bitTick);
		reqAge = txRequest ? 1 : reqAge + 1;
	end

	// Main sequence.
	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'h0;
		@(posedge sys_clk);
		axi_read(8'h68, {`RFF_RESP_OKAY, 24'h0, `RFF_RST_SYNC_MIN});
		axi_read(8'h6C, {`RFF_RESP_OKAY, 24'h0, `RFF_RST_MAX_SLOT});
		axi_read(8'h70, {`RFF_RESP_OKAY, 24'h0, `RFF_RST_CARD_CFG});
		axi_read(8'h74, {`RFF_RESP_SLVERR, 32'h0});
		axi_write(8'h74, 8'hFF, `RFF_RESP_SLVERR);
		check_lvl({11'h0, millerSens, millerTau}, 16'h000C);
		mil = lfsr[4:0];
		axi_write(8'h70, {mil, 3'h2}, `RFF_RESP_OKAY);
		axi_write(8'h71, 8'hFF, `RFF_RESP_OKAY);
		check_lvl({11'h0, millerSens, millerTau}, {11'h0, mil});
		axi_read(8'h70, {`RFF_RESP_OKAY, 24'h0, mil, 3'h2});
		for (int c = 0; c < 4; c++) begin
			axi_write(8'h68, {c[1:0], 6'h00}, `RFF_RESP_OKAY);
			check_lvl({13'h0, syncBytes}, 16'(c) + 16'(`RFF_SYNC_BASE));
		end
		check_lvl(syncWord, `RFF_SYNC_WORD);
		// Length bounds, random lengths, zero maximum, 106 kbit bypass.
		set_len(6'h03, 6'h05);
		foreach (lens[i]) pkt(lens[i]);
		for (int i = 0; i < 16; i++) begin
			pkt({3'h0, lfsr[5:0]});
			lfsr = lfsr_next(lfsr);
		end
		set_len(6'h00, 6'h00);
		pkt(9'h0FF);
		pkt(9'h100);
		pkt(9'h101);
		set_len(6'h03, 6'h05);
		rate106 <= 1'h1;
		@(posedge sys_clk);
		pkt(9'h002);
		pkt(9'h028);
		syncDetectEnable <= 1'h1;
		@(posedge sys_clk);
		pkt(9'h002);
		settle();
		{rate106, syncDetectEnable} <= 2'h0;
		// Short slot only in passive 424 kbit.
		for (int k = 0; k < 4; k++) begin
			axi_write(8'h6C, {1'h0, k[0], 6'h00}, `RFF_RESP_OKAY);
			passive424 <= k[1];
			repeat (2) @(posedge sys_clk);
			check_lvl({15'h0, slotHalf}, {15'h0, k[0] & k[1]});
		end
		// Anticollision end, hold bit on and off.
		axi_write(8'h6C, 8'h80, `RFF_RESP_OKAY);
		check_lvl({15'h0, activeAllowed}, 16'h0000);
		pulse_in(2);
		u_peer.pulse(2);
		repeat (3) @(posedge sys_clk);
		check_lvl(16'(doneCount), 16'h0000);
		u_peer.pulse(1);
		u_peer.pulse(2);
		repeat (3) @(posedge sys_clk);
		check_lvl(16'(doneCount), 16'h0001);
		axi_write(8'h6C, 8'h00, `RFF_RESP_OKAY);
		check_lvl({15'h0, activeAllowed}, 16'h0001);
		pulse_in(2);
		u_peer.pulse(2);
		repeat (3) @(posedge sys_clk);
		check_lvl(16'(doneCount), 16'h0002);
		// Halt set by hardware and software, cleared by RF reset.
		pulse_in(0);
		check_lvl({15'h0, halted}, 16'h0001);
		reqc(8'h26, 1'h1);
		reqc(8'h52, 1'h1);
		reqc(lfsr[7:0], 1'h1);
		pulse_in(1);
		check_lvl({15'h0, halted}, 16'h0000);
		reqc(8'h26, 1'h0);
		axi_write(8'h70, 8'h66, `RFF_RESP_OKAY);
		check_lvl({15'h0, halted}, 16'h0001);
		axi_read(8'h70, {`RFF_RESP_OKAY, 32'h66});
		reqc(8'h93, 1'h1);
		pulse_in(1);
		check_lvl({15'h0, halted}, 16'h0000);
		settle();
		// Early requests wait for the gap; late ones start at once.
		for (int e = 0; e < 4; e++) begin
			axi_write(8'h70, {5'h0C, 1'h0, e[1:0]}, `RFF_RESP_OKAY);
			u_peer.pulse(0);
			txQ.push_back({1'h0, 4'(7 + e)});
			pulse_in(3);
			settle();
		end
		repeat (60) @(posedge sys_clk);
		txQ.push_back(5'h11);
		pulse_in(3);
		settle();
		txBitAligned <= 1'h0;
		txQ.push_back(5'h1F);
		pulse_in(3);
		repeat (6) @(posedge sys_clk);
		check_lvl({15'h0, txHeld}, 16'h0001);
		txBitAligned <= 1'h1;
		settle();
		end_of_test();
	end
endmodule
